// >>> adtc_pkg.sv
// package: register map, field layout and types of the converter control block
package adtc_pkg;

    localparam logic [7:0] ADDR_REF_CTRL   = 8'h02;
    localparam logic [7:0] ADDR_EVT_CTRL   = 8'h03;
    localparam logic [7:0] ADDR_CLK_DIV    = 8'h04;
    localparam logic [7:0] ADDR_FLAGS      = 8'h06;
    localparam logic [7:0] ADDR_HI_LATCH   = 8'h07;
    localparam logic [7:0] ADDR_SAMP_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_CAL_LOW    = 8'h0c;
    localparam logic [7:0] ADDR_CAL_HIGH   = 8'h0d;
    localparam logic [7:0] ADDR_RES_LOW    = 8'h10;
    localparam logic [7:0] ADDR_RES_HIGH   = 8'h11;
    localparam logic [7:0] ADDR_CTRL_LOCAL = 8'h01;

    localparam logic [2:0] CLK_DIV_RESET   = 3'h2;
    localparam logic [2:0] ACT_NONE        = 3'h0;
    localparam logic [2:0] ACT_LOWEST      = 3'h1;
    localparam logic [2:0] ACT_FLUSH       = 3'h6;

    localparam logic [1:0] RES_12_RIGHT    = 2'h0;
    localparam logic [1:0] RES_OVERSAMPLE  = 2'h1;
    localparam logic [1:0] RES_8_RIGHT     = 2'h2;
    localparam logic [1:0] RES_12_LEFT     = 2'h3;

    localparam int CNT_W = 9;
    localparam int DIV_LOG_BASE = 2;
    localparam int FLAG_BIT = 0;
    localparam int TEMP_BIT = 0;
    localparam int CONV_HALF_CYCLES = 24;

    typedef struct packed {
        logic [1:0] pad;
        logic [2:0] line_select;
        logic [2:0] action;
    } adtc_evt_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adtc_bus_t;

    typedef enum logic [1:0] {
        ADTC_IDLE,
        ADTC_SAMPLE,
        ADTC_CONVERT
    } adtc_state_t;

endpackage

// >>> adtc_top.sv
// top: converter control registers, event trigger, clock prescaler and sequencer
//
// Behaviour
// - bit 0 of reference control enables temperature sensor
// - line select picks one of eight event channels
// - action 001 triggers conversion; 000 disables events
// - action 110 flushes and restarts on event
// - adc clock divides by 4 through 512
// - done flag sets on completion; in compare mode only on completion with compare hit
// - done flag clears when interrupt vector executes
// - writing one clears done flag
// - unused flag, sample, calibration bits read zero
// - low byte read latches high byte
// - high byte latch is plain read/write register
// - sample length is value plus one halves
// - calibration split low eight, high four bits
// - result low byte layout follows adjust mode
// - flush aborts conversion, restarts divider next edge
// - 12-bit right adjusted high byte holds bits 11:8
module adtc_top
    import adtc_pkg::*;
#(
    parameter int RESULT_W = 12
)
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [7:0]  EVENT_IN,
    input  wire logic        VECTOR_ACK,
    input  wire logic        COMPARE_MODE,
    input  wire logic        COMPARE_HIT,
    input  wire logic [11:0] CONV_VALUE,
    output logic             TEMP_SENSOR_ON,
    output logic             ADC_TICK,
    output logic             SAMPLING,
    output logic             CONV_DONE,
    output logic      [11:0] CALIBRATION
);

    if (RESULT_W != 12)
    begin : g_bad
        $error("result width must be 12");
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    adtc_bus_t   bus;
    adtc_evt_t   evt_ctrl;
    logic [2:0]  clk_div;
    logic        done_flag;
    logic [7:0]  hi_latch;
    logic [5:0]  sample_half_cycles;
    logic [7:0]  cal_low;
    logic [3:0]  cal_high;
    logic        temp_sensor_enable;
    logic [1:0]  resolution;
    logic [11:0] conversion_result;
    logic [CNT_W-1:0] div_cnt;
    logic        half_tick;
    logic [6:0]  phase_cnt;
    adtc_state_t state;
    logic        trigger;
    logic        flush;
    logic        pending;
    logic [7:0]  ev_s1;
    logic [7:0]  ev_s2;
    logic [7:0]  ev_s3;
    logic        ev_prev;
    logic        ev_rise;
    logic [7:0]  res_low_view;
    logic [7:0]  res_high_view;

    assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    function automatic logic hit(input adtc_bus_t b, input logic [7:0] a);
        hit = b.addr == a;
    endfunction

    // ----------------------------------------
    // software writes
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            evt_ctrl           <= '0;
            clk_div            <= CLK_DIV_RESET;
            sample_half_cycles <= '0;
            cal_low            <= '0;
            cal_high           <= '0;
            temp_sensor_enable <= 1'b0;
            resolution         <= RES_12_RIGHT;
        end
        else if (bus.wr)
        begin
            if (hit(bus, ADDR_REF_CTRL))
                temp_sensor_enable <= bus.wdata[TEMP_BIT];
            if (hit(bus, ADDR_EVT_CTRL))
                evt_ctrl <= {2'b00, bus.wdata[5:0]};
            if (hit(bus, ADDR_CLK_DIV))
                clk_div <= bus.wdata[2:0];
            if (hit(bus, ADDR_SAMP_CTRL))
                sample_half_cycles <= bus.wdata[5:0];
            if (hit(bus, ADDR_CAL_LOW))
                cal_low <= bus.wdata;
            if (hit(bus, ADDR_CAL_HIGH))
                cal_high <= bus.wdata[3:0];
            if (hit(bus, ADDR_CTRL_LOCAL))
                resolution <= bus.wdata[2:1];
        end
    end

    assign TEMP_SENSOR_ON = temp_sensor_enable;
    assign CALIBRATION    = {cal_high, cal_low};

    // ----------------------------------------
    // event inputs
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ev_s1   <= '0;
            ev_s2   <= '0;
            ev_s3   <= '0;
            ev_prev <= 1'b0;
        end
        else
        begin
            ev_s1   <= EVENT_IN;
            ev_s2   <= ev_s1;
            ev_s3   <= ev_s2;
            if (ev_s2[evt_ctrl.line_select] == ev_s3[evt_ctrl.line_select])
                ev_prev <= ev_s3[evt_ctrl.line_select];
        end
    end

    assign ev_rise = !ev_prev && ev_s2[evt_ctrl.line_select]
                     && ev_s3[evt_ctrl.line_select];
    assign trigger = ev_rise && (evt_ctrl.action == ACT_LOWEST
                     || evt_ctrl.action == ACT_FLUSH);
    assign flush   = ev_rise && evt_ctrl.action == ACT_FLUSH;

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST || flush)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    // half tick marks each half period of the adc clock
    logic [CNT_W-1:0] half_mask;
    assign half_mask = CNT_W'((1 << (clk_div + DIV_LOG_BASE - 1)) - 1);
    assign half_tick = (div_cnt & half_mask) == half_mask;
    assign ADC_TICK  = half_tick
                       && div_cnt[clk_div + DIV_LOG_BASE - 1];

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state     <= ADTC_IDLE;
            phase_cnt <= '0;
            pending   <= 1'b0;
        end
        else if (flush)
        begin
            state     <= ADTC_SAMPLE;
            phase_cnt <= '0;
            pending   <= 1'b0;
        end
        else
        begin
            case (state)
                ADTC_IDLE:
                begin
                    if (trigger || pending)
                    begin
                        state     <= ADTC_SAMPLE;
                        phase_cnt <= '0;
                        pending   <= 1'b0;
                    end
                end
                ADTC_SAMPLE:
                begin
                    if (trigger)
                        pending <= 1'b1;
                    if (half_tick)
                    begin
                        if (phase_cnt == {1'b0, sample_half_cycles})
                        begin
                            state     <= ADTC_CONVERT;
                            phase_cnt <= '0;
                        end
                        else
                            phase_cnt <= phase_cnt + 1'b1;
                    end
                end
                ADTC_CONVERT:
                begin
                    if (trigger)
                        pending <= 1'b1;
                    if (half_tick)
                    begin
                        if (phase_cnt == 7'(CONV_HALF_CYCLES - 1))
                            state <= ADTC_IDLE;
                        else
                            phase_cnt <= phase_cnt + 1'b1;
                    end
                end
                default:
                    state <= ADTC_IDLE;
            endcase
        end
    end

    assign SAMPLING  = state == ADTC_SAMPLE;
    assign CONV_DONE = state == ADTC_CONVERT && half_tick && !flush
                       && phase_cnt == 7'(CONV_HALF_CYCLES - 1);

    always_ff @(posedge CLK)
    begin
        if (RST)
            conversion_result <= '0;
        else if (CONV_DONE)
            conversion_result <= CONV_VALUE;
    end

    // ----------------------------------------
    // done flag
    // ----------------------------------------
    logic flag_set;
    assign flag_set = COMPARE_MODE ? (CONV_DONE && COMPARE_HIT) : CONV_DONE;

    always_ff @(posedge CLK)
    begin
        if (RST)
            done_flag <= 1'b0;
        else if (flag_set)
            done_flag <= 1'b1;
        else if (VECTOR_ACK)
            done_flag <= 1'b0;
        else if (bus.wr && hit(bus, ADDR_FLAGS) && bus.wdata[FLAG_BIT])
            done_flag <= 1'b0;
    end

    // ----------------------------------------
    // result views
    // ----------------------------------------
    always_comb
    begin
        case (resolution)
            RES_12_LEFT:
            begin
                res_low_view  = {conversion_result[3:0], 4'h0};
                res_high_view = conversion_result[11:4];
            end
            RES_8_RIGHT:
            begin
                res_low_view  = conversion_result[7:0];
                res_high_view = 8'h00;
            end
            default:
            begin
                res_low_view  = conversion_result[7:0];
                res_high_view = {4'h0, conversion_result[11:8]};
            end
        endcase
    end

    // ----------------------------------------
    // high byte latch
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
            hi_latch <= '0;
        else if (bus.rd && hit(bus, ADDR_RES_LOW))
            hi_latch <= res_high_view;
        else if (bus.rd && hit(bus, ADDR_CAL_LOW))
            hi_latch <= {4'h0, cal_high};
        else if (bus.wr && hit(bus, ADDR_HI_LATCH))
            hi_latch <= bus.wdata;
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
            RDATA <= '0;
        else if (bus.rd)
        begin
            case (bus.addr)
                ADDR_CTRL_LOCAL: RDATA <= {5'h00, resolution, 1'b0};
                ADDR_REF_CTRL:   RDATA <= {7'h00, temp_sensor_enable};
                ADDR_EVT_CTRL:   RDATA <= evt_ctrl;
                ADDR_CLK_DIV:    RDATA <= {5'h00, clk_div};
                ADDR_FLAGS:      RDATA <= {7'h00, done_flag};
                ADDR_HI_LATCH:   RDATA <= hi_latch;
                ADDR_SAMP_CTRL:  RDATA <= {2'b00, sample_half_cycles};
                ADDR_CAL_LOW:    RDATA <= cal_low;
                ADDR_CAL_HIGH:   RDATA <= {4'h0, cal_high};
                ADDR_RES_LOW:    RDATA <= res_low_view;
                ADDR_RES_HIGH:   RDATA <= hi_latch;
                default:         RDATA <= 8'h00;
            endcase
        end
        else
            RDATA <= '0;
    end

endmodule

// >>> adtc_props.sv
// checker: port-level properties of the converter control block
module adtc_props
    import adtc_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [7:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic [7:0]  EVENT_IN,
    input wire logic        VECTOR_ACK,
    input wire logic        COMPARE_MODE,
    input wire logic        COMPARE_HIT,
    input wire logic [11:0] CONV_VALUE,
    input wire logic        TEMP_SENSOR_ON,
    input wire logic        ADC_TICK,
    input wire logic        SAMPLING,
    input wire logic        CONV_DONE,
    input wire logic [11:0] CALIBRATION
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_flag_pad; RD && ADDR == ADDR_FLAGS |=> RDATA[7:1] == 7'h00; endproperty
    a_flag_pad: assert property (p_flag_pad) else $error("flag pad bits set");
    property p_samp_pad; RD && ADDR == ADDR_SAMP_CTRL |=> RDATA[7:6] == 2'h0; endproperty
    a_samp_pad: assert property (p_samp_pad) else $error("sample pad bits set");
    property p_calibration_high_pad; RD && ADDR == ADDR_CAL_HIGH |=> RDATA[7:4] == 4'h0; endproperty
    a_calibration_high_pad: assert property (p_calibration_high_pad) else $error("cal high pad bits set");
    property p_temp_on;
        WR && ADDR == ADDR_REF_CTRL |=> TEMP_SENSOR_ON == $past(WDATA[0]);
    endproperty
    a_temp_on: assert property (p_temp_on) else $error("sensor enable wrong");
    property p_cal_split;
        WR && ADDR == ADDR_CAL_HIGH |=> CALIBRATION[11:8] == $past(WDATA[3:0]);
    endproperty
    a_cal_split: assert property (p_cal_split) else $error("cal high wrong");
    property p_latch_rw;
        WR && ADDR == ADDR_HI_LATCH ##1 RD && ADDR == ADDR_HI_LATCH |=> RDATA == $past(WDATA, 2);
    endproperty
    a_latch_rw: assert property (p_latch_rw) else $error("latch readback wrong");
    property p_done_set;
        CONV_DONE && !COMPARE_MODE ##1 RD && ADDR == ADDR_FLAGS |=> RDATA[0];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");
    property p_vec_clr;
        VECTOR_ACK && !CONV_DONE ##1 RD && ADDR == ADDR_FLAGS |=> !RDATA[0];
    endproperty
    a_vec_clr: assert property (p_vec_clr) else $error("vector ack kept flag");
    property p_tick; ADC_TICK |=> !ADC_TICK; endproperty
    a_tick: assert property (p_tick) else $error("tick longer than a cycle");
endmodule

bind adtc_top adtc_props adtc_props_i (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .EVENT_IN(EVENT_IN), .VECTOR_ACK(VECTOR_ACK),
    .COMPARE_MODE(COMPARE_MODE), .COMPARE_HIT(COMPARE_HIT), .CONV_VALUE(CONV_VALUE),
    .TEMP_SENSOR_ON(TEMP_SENSOR_ON), .ADC_TICK(ADC_TICK), .SAMPLING(SAMPLING),
    .CONV_DONE(CONV_DONE), .CALIBRATION(CALIBRATION));

// >>> adtc_evt_model.sv
// event channel model: raises one channel line for five cycles
module adtc_evt_model
(
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [2:0] ch,
    output logic      [7:0] event_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold = 3'h0;
    logic [2:0] line = 3'h0;
    always_ff @(posedge clk)
    begin
        if (fire)
        begin
            line <= ch;
            hold <= 3'h5;
        end
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end
    assign event_out = (hold != 3'h0) ? (8'h01 << line) : 8'h00;
endmodule

// >>> adc_trigger_clock_result_regs_tb.sv
// bench: registers, prescaler, event trigger and flush of the converter block
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module adc_trigger_clock_result_regs_tb
    import adtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} adtc_row_t;
    logic CLK = 0, RST = 1, WR = 0, RD = 0, VECTOR_ACK = 0, COMPARE_MODE = 0, fire = 0;
    logic COMPARE_HIT = 0;
    logic [7:0] ADDR = 0, WDATA = 0, RDATA, EVENT_IN;
    logic [2:0] ch = 0;
    logic [11:0] CONV_VALUE = 12'habc, CALIBRATION;
    logic TEMP_SENSOR_ON, ADC_TICK, SAMPLING, CONV_DONE;
    int failures = 0, compares = 0, n;
    logic [7:0] ign [4] = '{8'h18, 8'h1a, 8'h1f, 8'h19};
    adtc_row_t rows [14] = '{'{0, ADDR_CLK_DIV, 0, 8'h02}, '{0, ADDR_FLAGS, 0, 0},
        '{0, ADDR_HI_LATCH, 0, 0}, '{0, ADDR_RES_LOW, 0, 0}, '{1, ADDR_EVT_CTRL, 8'h3f, 8'h3f},
        '{1, ADDR_CLK_DIV, 8'h07, 8'h07}, '{1, ADDR_HI_LATCH, 8'ha5, 8'ha5},
        '{1, ADDR_SAMP_CTRL, 8'h3f, 8'h3f}, '{1, ADDR_CAL_LOW, 8'h5a, 8'h5a},
        '{1, ADDR_CAL_HIGH, 8'h0f, 8'h0f}, '{1, ADDR_REF_CTRL, 8'h01, 8'h01},
        '{1, 8'h30, 8'hff, 8'h00}, '{0, ADDR_CAL_LOW, 0, 8'h5a}, '{0, ADDR_HI_LATCH, 0, 8'h0f}};

    adtc_top adtc_top_i (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .EVENT_IN(EVENT_IN), .VECTOR_ACK(VECTOR_ACK), .COMPARE_MODE(COMPARE_MODE),
        .COMPARE_HIT(COMPARE_HIT), .CONV_VALUE(CONV_VALUE), .TEMP_SENSOR_ON(TEMP_SENSOR_ON),
        .ADC_TICK(ADC_TICK), .SAMPLING(SAMPLING), .CONV_DONE(CONV_DONE),
        .CALIBRATION(CALIBRATION));
    adtc_evt_model adtc_evt_model_i (.clk(CLK), .fire(fire), .ch(ch), .event_out(EVENT_IN));

    initial
    begin
        forever #4 CLK = ~CLK;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        WR <= w; RD <= !w; ADDR <= a; WDATA <= d;
        @(posedge CLK);
        WR <= 0; RD <= 0;
        #1;
    endtask
    task automatic ev(input logic [2:0] c);
        ch <= c; fire <= 1;
        @(posedge CLK);
        fire <= 0;
        #1;
    endtask
    task automatic wt(input bit tick, input int lim, input bit must, output int c);
        c = 0;
        do begin @(posedge CLK); #1; c++; end
        while ((tick ? ADC_TICK : CONV_DONE) !== 1'b1 && c < lim);
        if (must && c >= lim)
        begin
            failures++;
            test_done();
        end
        if (!tick)
        begin
            @(posedge CLK);
            #1;
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge CLK);
        RST <= 0;
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (rows[i].w) bus(0, rows[i].a, 8'h00);
            `CHK(RDATA, rows[i].e);
        end
        `CHK(CALIBRATION, 12'hf5a);
        `CHK(TEMP_SENSOR_ON, 1'b1);
        for (int k = 0; k < 8; k++)
        begin
            bus(1, ADDR_CLK_DIV, 8'(k));
            wt(1, 1100, 1, n);
            wt(1, 1100, 1, n);
            `CHK(n, 4 << k);
        end
        bus(1, ADDR_CLK_DIV, 8'h00);
        bus(1, ADDR_SAMP_CTRL, 8'h00);
        foreach (ign[i])
        begin
            bus(1, ADDR_EVT_CTRL, ign[i]);
            ev(i == 3 ? 3'h2 : 3'h3);
            wt(0, 150, 0, n);
            `CHK(n, 150);
        end
        ev(3);
        wt(0, 200, 1, n);
        bus(0, ADDR_FLAGS, 8'h00);
        `CHK(RDATA, 8'h01);
        `CHK(n inside {[50:60]}, 1'b1);
        bus(0, ADDR_RES_LOW, 8'h00);
        `CHK(RDATA, 8'hbc);
        bus(0, ADDR_RES_HIGH, 8'h00);
        `CHK(RDATA, 8'h0a);
        bus(1, ADDR_FLAGS, 8'h00);
        bus(0, ADDR_FLAGS, 8'h00);
        `CHK(RDATA, 8'h01);
        bus(1, ADDR_FLAGS, 8'h01);
        bus(0, ADDR_FLAGS, 8'h00);
        `CHK(RDATA, 8'h00);
        COMPARE_MODE <= 1;
        bus(1, ADDR_CTRL_LOCAL, 8'h06);
        ev(3);
        wt(0, 200, 1, n);
        bus(0, ADDR_FLAGS, 8'h00);
        `CHK(RDATA, 8'h00);
        bus(0, ADDR_RES_LOW, 8'h00);
        `CHK(RDATA, 8'hc0);
        COMPARE_HIT <= 1;
        ev(3);
        repeat (4) @(posedge CLK);
        #1;
        `CHK(SAMPLING, 1'b1);
        wt(0, 200, 1, n);
        bus(0, ADDR_FLAGS, 8'h00);
        `CHK(RDATA, 8'h01);
        bus(1, ADDR_FLAGS, 8'h01);
        COMPARE_HIT <= 0;
        COMPARE_MODE <= 0;
        bus(1, ADDR_EVT_CTRL, 8'h1e);
        ev(3);
        repeat (30) @(posedge CLK);
        ev(3);
        wt(0, 200, 1, n);
        `CHK(n inside {[50:60]}, 1'b1);
        VECTOR_ACK <= 1;
        @(posedge CLK);
        VECTOR_ACK <= 0;
        bus(0, ADDR_FLAGS, 8'h00);
        `CHK(RDATA, 8'h00);
        RST <= 1;
        repeat (2) @(posedge CLK);
        RST <= 0;
        bus(0, ADDR_CLK_DIV, 8'h00);
        `CHK(RDATA, 8'h02);
        test_done();
    end
endmodule
